// file: design/qda_params.svh
// constants for the quad dac address and control decoder
`ifndef QDA_PARAMS_SVH
`define QDA_PARAMS_SVH

// address byte layout
`define QDA_ADDR_FIXED      5'h13
`define QDA_ADDR_FIX_MSB    7
`define QDA_ADDR_FIX_LSB    3
`define QDA_ADDR_SEL_MSB    2
`define QDA_ADDR_SEL_LSB    1
`define QDA_ADDR_RW_BIT     0
`define QDA_ADDR_BCAST      8'h90

// control byte layout
`define QDA_CTRL_EXT_MSB    7
`define QDA_CTRL_EXT_LSB    6
`define QDA_CTRL_LOAD_MSB   5
`define QDA_CTRL_LOAD_LSB   4
`define QDA_CTRL_CHAN_MSB   2
`define QDA_CTRL_CHAN_LSB   1
`define QDA_CTRL_PD_BIT     0
`define QDA_CTRL_RESET      8'h00

// load modes
`define QDA_LOAD_TEMP       2'h0
`define QDA_LOAD_DIRECT     2'h1
`define QDA_LOAD_ALL        2'h2
`define QDA_LOAD_BCAST      2'h3

// power-down code field in the upper data byte
`define QDA_PD_MSB          7
`define QDA_PD_LSB          6
`define QDA_PD_NORMAL       2'h0

// reset values and sizes
`define QDA_DATA_RESET      12'h000
`define QDA_NUM_CH          4
`define QDA_RING_AW         3
`define QDA_PIN_SETTLE      3'h3

`endif

// file: design/qda_pkg.sv
// types and shared helpers for the quad dac address and control decoder
package qda_pkg;

	typedef enum logic [2:0] {
		QDA_IDLE,
		QDA_BITS,
		QDA_ACK_WAIT,
		QDA_ACK_HOLD,
		QDA_ACK_END,
		QDA_IGNORE
	} qda_phase_e;

	typedef enum logic [1:0] {
		QDA_K_ADDR,
		QDA_K_CTRL,
		QDA_K_MSB,
		QDA_K_LSB
	} qda_kind_e;

	typedef logic [3:0] qda_ptr_t;

	// binary to gray for the crossing pointer
	function automatic qda_ptr_t qda_bin2gray(input qda_ptr_t b);
		return b ^ (b >> 1);
	endfunction

	// gray back to binary on the reading side
	function automatic qda_ptr_t qda_gray2bin(input qda_ptr_t g);
		qda_ptr_t b;
		b[3] = g[3];
		for (int i = 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

endpackage

// file: design/qda_link_if.sv
// bit ring and write pointer passed from the scl domain to the core
interface qda_link_if;
	import qda_pkg::*;
	qda_ptr_t   wptr_gray;
	logic [7:0] ring;

	modport link (output wptr_gray, output ring);
	modport core (input wptr_gray, input ring);
endinterface

// file: design/qda_link_capture.sv
// scl-domain bit capture into a small ring with a gray write pointer
module qda_link_capture
	import qda_pkg::*;
(
	// link clock and reset
	input  wire logic i_scl_clk,
	input  wire logic i_srst,
	// serial data pin
	input  wire logic i_sda,
	// toward the core
	qda_link_if.link  lnk
);

	logic     rst_meta;
	logic     rst_sync;
	qda_ptr_t wbin;
	qda_ptr_t wgray;
	logic [7:0] ring;
	qda_ptr_t next_wbin;
	qda_ptr_t next_wgray;
	logic [7:0] next_ring;

	// reset crosses in on scl edges; core resyncs its pointer while idle anyway
	always_ff @(posedge i_scl_clk) begin
		rst_meta <= i_srst;
		rst_sync <= rst_meta;
	end

	// every scl rise stores one sda sample and advances the pointer
	always_comb begin
		next_wbin            = wbin + 4'h1;
		next_ring            = ring;
		next_ring[wbin[2:0]] = i_sda;
		if (rst_sync) begin
			next_wbin = 4'h0;
			next_ring = 8'h00;
		end
		next_wgray = qda_bin2gray(next_wbin);
	end

	always_ff @(posedge i_scl_clk) begin
		wbin  <= next_wbin;
		wgray <= next_wgray;
		ring  <= next_ring;
	end

	// gray pointer comes straight from a flop, so it never glitches
	assign lnk.wptr_gray = wgray;
	assign lnk.ring      = ring;

endmodule

// file: design/qda_decoder.sv
// quad dac i2c address and control byte decoder with channel register bank
`include "qda_params.svh"

// Function
// - first byte after start is address; claim own address only when top five bits are 10011
// - address byte device-select bits must equal the two lower address pins
// - address pins are latched once after power-up; later changes are ignored
// - two address-byte bits plus two control bits give sixteen distinct devices
// - also accept broadcast address byte 1001 0000
// - broadcast address is acknowledged whatever the address pins carry
// - broadcast is honoured for writes only; master never reads with it
// - control top bits must match upper address pins, except broadcast update mode
// - load mode 00 writes only the selected holding register
// - load mode 01 writes selected holding and dac registers
// - load mode 10 writes selected channel and loads other dacs from holding
// - load mode 11 ignores address match and channel select, updates all four
// - mode 11 with upper channel bit clear loads all dacs from holding
// - mode 11 with upper channel bit set writes new data or power-down everywhere
// - channel select 00,01,10,11 picks channel A,B,C,D
// - update happens on falling scl of the ack after the lower data byte
module qda_decoder
	import qda_pkg::*;
#(
	parameter int DATA_W = 12
)(
	// reference clock and reset
	input  wire logic                              i_ref_clk,
	input  wire logic                              i_srst,
	// i2c link
	input  wire logic                              i_scl_clk,
	input  wire logic                              i_scl,
	input  wire logic                              i_sda,
	output logic                                   o_sda,
	output logic                                   o_sda_oe,
	// address strap pins
	input  wire logic [1:0]                        i_dev_sel_pins,
	input  wire logic [1:0]                        i_ext_addr_pins,
	// channel register bank
	output logic [`QDA_NUM_CH*DATA_W-1:0]          o_hold_code,
	output logic [`QDA_NUM_CH*2-1:0]               o_hold_pd,
	output logic [`QDA_NUM_CH*DATA_W-1:0]          o_dac_code,
	output logic [`QDA_NUM_CH*2-1:0]               o_dac_pd,
	// status
	output logic [7:0]                             o_ctrl,
	output logic                                   o_update,
	output logic                                   o_claimed
);

	if (DATA_W != 12) begin : g_bad_width
		$error("qda_decoder: data path is built for 12-bit codes only");
	end

	qda_link_if lnk ();

	qda_link_capture u_link (
		.i_scl_clk (i_scl_clk),
		.i_srst    (i_srst),
		.i_sda     (i_sda),
		.lnk       (lnk.link)
	);

	// two-flop synchronisers for pins, pointer and edge history
	logic     scl_meta, scl_sync, scl_prev;
	logic     sda_meta, sda_sync, sda_prev;
	logic [1:0] dev_meta, dev_sync, ext_meta, ext_sync;
	qda_ptr_t wg_meta, wg_sync;

	always_ff @(posedge i_ref_clk) begin
		scl_meta <= i_scl;
		scl_sync <= scl_meta;
		scl_prev <= scl_sync;
		sda_meta <= i_sda;
		sda_sync <= sda_meta;
		sda_prev <= sda_sync;
		dev_meta <= i_dev_sel_pins;
		dev_sync <= dev_meta;
		ext_meta <= i_ext_addr_pins;
		ext_sync <= ext_meta;
		wg_meta  <= lnk.wptr_gray;
		wg_sync  <= wg_meta;
	end

	// bus conditions seen from the synchronised pins
	logic     start_det, stop_det, scl_fall;
	qda_ptr_t wbin_sync;

	assign start_det = scl_sync && scl_prev && sda_prev && !sda_sync;
	assign stop_det  = scl_sync && scl_prev && !sda_prev && sda_sync;
	assign scl_fall  = scl_prev && !scl_sync;
	assign wbin_sync = qda_gray2bin(wg_sync);

	// strap latch: pins settle through the sync, then freeze once
	logic [2:0] settle_cnt, next_settle_cnt;
	logic       latched, next_latched;
	logic [1:0] dev_addr, next_dev_addr, ext_addr, next_ext_addr;

	always_comb begin
		next_settle_cnt = settle_cnt;
		next_latched    = latched;
		next_dev_addr   = dev_addr;
		next_ext_addr   = ext_addr;
		if (!latched) begin
			if (settle_cnt == `QDA_PIN_SETTLE) begin
				next_latched  = 1'b1;
				next_dev_addr = dev_sync;
				next_ext_addr = ext_sync;
			end else begin
				next_settle_cnt = settle_cnt + 3'h1;
			end
		end
		if (i_srst) begin
			next_settle_cnt = 3'h0;
			next_latched    = 1'b0;
			next_dev_addr   = 2'h0;
			next_ext_addr   = 2'h0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		settle_cnt <= next_settle_cnt;
		latched    <= next_latched;
		dev_addr   <= next_dev_addr;
		ext_addr   <= next_ext_addr;
	end

	// byte framing, acknowledge and control decoding
	qda_phase_e phase, next_phase;
	qda_kind_e  kind, next_kind;
	qda_ptr_t   rptr, next_rptr;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, next_shreg;
	logic [7:0] ctrl, next_ctrl;
	logic [7:0] msb, next_msb;
	logic [7:0] lsb, next_lsb;
	logic       ack_ok, next_ack_ok;
	logic       sda_oe, next_sda_oe;
	logic       fire, next_fire;
	logic       claimed, next_claimed;
	logic       pop_bit;
	logic [7:0] byte_in;

	always_comb begin
		next_phase   = phase;
		next_kind    = kind;
		next_rptr    = rptr;
		next_bit_cnt = bit_cnt;
		next_shreg   = shreg;
		next_ctrl    = ctrl;
		next_msb     = msb;
		next_lsb     = lsb;
		next_ack_ok  = ack_ok;
		next_sda_oe  = sda_oe;
		next_fire    = 1'b0;
		next_claimed = claimed;
		pop_bit      = lnk.ring[rptr[2:0]];
		byte_in      = {shreg[6:0], pop_bit};
		case (phase)
			QDA_IDLE, QDA_IGNORE: begin
				// drop stray bits; nothing on the bus concerns us here
				next_rptr = wbin_sync;
			end
			QDA_BITS: begin
				if (rptr != wbin_sync) begin
					next_rptr    = rptr + 4'h1;
					next_shreg   = byte_in;
					next_bit_cnt = bit_cnt + 3'h1;
					if (bit_cnt == 3'h7) begin
						next_phase = QDA_ACK_WAIT;
						case (kind)
							QDA_K_ADDR: begin
								// own address for writes, or broadcast
								next_ack_ok =
									(byte_in[`QDA_ADDR_FIX_MSB:`QDA_ADDR_FIX_LSB]
										== `QDA_ADDR_FIXED
									&& byte_in[`QDA_ADDR_SEL_MSB:`QDA_ADDR_SEL_LSB]
										== dev_addr
									&& !byte_in[`QDA_ADDR_RW_BIT])
									|| byte_in == `QDA_ADDR_BCAST;
							end
							QDA_K_CTRL: begin
								next_ctrl   = byte_in;
								next_ack_ok = 1'b1;
							end
							QDA_K_MSB: begin
								next_msb    = byte_in;
								next_ack_ok = 1'b1;
							end
							default: begin
								next_lsb    = byte_in;
								next_ack_ok = 1'b1;
							end
						endcase
					end
				end
			end
			QDA_ACK_WAIT: begin
				// pull sda low from the eighth falling edge
				if (scl_fall) begin
					next_sda_oe = ack_ok;
					next_phase  = QDA_ACK_HOLD;
				end
			end
			QDA_ACK_HOLD: begin
				// ninth rise is the ack clock; its sample is ours
				if (rptr != wbin_sync) begin
					next_rptr  = rptr + 4'h1;
					next_phase = QDA_ACK_END;
				end
			end
			QDA_ACK_END: begin
				if (scl_fall) begin
					next_sda_oe = 1'b0;
					if (!ack_ok) begin
						next_phase = QDA_IGNORE;
					end else begin
						next_phase = QDA_BITS;
						case (kind)
							QDA_K_ADDR: begin
								next_kind    = QDA_K_CTRL;
								next_claimed = 1'b1;
							end
							QDA_K_CTRL: next_kind = QDA_K_MSB;
							QDA_K_MSB:  next_kind = QDA_K_LSB;
							default: begin
								// control byte stays; pairs repeat
								next_kind = QDA_K_MSB;
								next_fire = 1'b1;
							end
						endcase
					end
				end
			end
			default: next_phase = QDA_IDLE;
		endcase
		if (start_det) begin
			next_phase   = QDA_BITS;
			next_kind    = QDA_K_ADDR;
			next_rptr    = wbin_sync;
			next_bit_cnt = 3'h0;
			next_sda_oe  = 1'b0;
			next_claimed = 1'b0;
		end else if (stop_det) begin
			next_phase   = QDA_IDLE;
			next_sda_oe  = 1'b0;
			next_claimed = 1'b0;
		end
		if (i_srst) begin
			next_phase   = QDA_IDLE;
			next_kind    = QDA_K_ADDR;
			next_rptr    = wbin_sync;
			next_bit_cnt = 3'h0;
			next_shreg   = 8'h00;
			next_ctrl    = `QDA_CTRL_RESET;
			next_msb     = 8'h00;
			next_lsb     = 8'h00;
			next_ack_ok  = 1'b0;
			next_sda_oe  = 1'b0;
			next_fire    = 1'b0;
			next_claimed = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		phase   <= next_phase;
		kind    <= next_kind;
		rptr    <= next_rptr;
		bit_cnt <= next_bit_cnt;
		shreg   <= next_shreg;
		ctrl    <= next_ctrl;
		msb     <= next_msb;
		lsb     <= next_lsb;
		ack_ok  <= next_ack_ok;
		sda_oe  <= next_sda_oe;
		fire    <= next_fire;
		claimed <= next_claimed;
	end

	// channel register bank, updated one cycle after the update pulse
	logic [DATA_W-1:0] hold_code [`QDA_NUM_CH];
	logic [DATA_W-1:0] dac_code  [`QDA_NUM_CH];
	logic [1:0]        hold_pd   [`QDA_NUM_CH];
	logic [1:0]        dac_pd    [`QDA_NUM_CH];
	logic [DATA_W-1:0] next_hold_code [`QDA_NUM_CH];
	logic [DATA_W-1:0] next_dac_code  [`QDA_NUM_CH];
	logic [1:0]        next_hold_pd   [`QDA_NUM_CH];
	logic [1:0]        next_dac_pd    [`QDA_NUM_CH];
	logic [1:0]        load_mode;
	logic [1:0]        chan;
	logic              pd_flag, ext_ok, wr_sel, wr_all;
	logic [DATA_W-1:0] new_code;
	logic [1:0]        new_pd;

	// bit three of the control byte is never looked at
	assign load_mode = ctrl[`QDA_CTRL_LOAD_MSB:`QDA_CTRL_LOAD_LSB];
	assign chan      = ctrl[`QDA_CTRL_CHAN_MSB:`QDA_CTRL_CHAN_LSB];
	assign pd_flag   = ctrl[`QDA_CTRL_PD_BIT];
	assign ext_ok    = ctrl[`QDA_CTRL_EXT_MSB:`QDA_CTRL_EXT_LSB] == ext_addr;
	assign new_code  = {msb, lsb[7:4]};
	assign new_pd    = msb[`QDA_PD_MSB:`QDA_PD_LSB];

	always_comb begin
		wr_sel = 1'b0;
		wr_all = 1'b0;
		for (int i = 0; i < `QDA_NUM_CH; i++) begin
			next_hold_code[i] = hold_code[i];
			next_dac_code[i]  = dac_code[i];
			next_hold_pd[i]   = hold_pd[i];
			next_dac_pd[i]    = dac_pd[i];
		end
		if (fire) begin
			for (int i = 0; i < `QDA_NUM_CH; i++) begin
				wr_sel = (load_mode != `QDA_LOAD_BCAST) && ext_ok
					&& chan == 2'(i);
				wr_all = (load_mode == `QDA_LOAD_BCAST)
					&& ctrl[`QDA_CTRL_CHAN_MSB];
				// a data write leaves power-down; a pd write keeps the code
				if (wr_sel || wr_all) begin
					if (pd_flag) begin
						next_hold_pd[i] = new_pd;
					end else begin
						next_hold_code[i] = new_code;
						next_hold_pd[i]   = `QDA_PD_NORMAL;
					end
				end
				if ((wr_sel && load_mode != `QDA_LOAD_TEMP) || wr_all) begin
					if (pd_flag) begin
						next_dac_pd[i] = new_pd;
					end else begin
						next_dac_code[i] = new_code;
						next_dac_pd[i]   = `QDA_PD_NORMAL;
					end
				end
				if ((load_mode == `QDA_LOAD_ALL && ext_ok && chan != 2'(i))
					|| (load_mode == `QDA_LOAD_BCAST
					&& !ctrl[`QDA_CTRL_CHAN_MSB])) begin
					next_dac_code[i] = hold_code[i];
					next_dac_pd[i]   = hold_pd[i];
				end
				// mode 00 touches only the holding side
			end
		end
		if (i_srst) begin
			for (int i = 0; i < `QDA_NUM_CH; i++) begin
				next_hold_code[i] = `QDA_DATA_RESET;
				next_dac_code[i]  = `QDA_DATA_RESET;
				next_hold_pd[i]   = `QDA_PD_NORMAL;
				next_dac_pd[i]    = `QDA_PD_NORMAL;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		hold_code <= next_hold_code;
		dac_code  <= next_dac_code;
		hold_pd   <= next_hold_pd;
		dac_pd    <= next_dac_pd;
	end

	// flatten the bank onto the ports, channel a in the low slice
	always_comb begin
		for (int i = 0; i < `QDA_NUM_CH; i++) begin
			o_hold_code[i*DATA_W +: DATA_W] = hold_code[i];
			o_dac_code[i*DATA_W +: DATA_W]  = dac_code[i];
			o_hold_pd[i*2 +: 2]             = hold_pd[i];
			o_dac_pd[i*2 +: 2]              = dac_pd[i];
		end
	end

	// open-drain: only ever drive low
	assign o_sda     = 1'b0;
	assign o_sda_oe  = sda_oe;
	assign o_ctrl    = ctrl;
	assign o_update  = fire;
	assign o_claimed = claimed;

endmodule

// file: test/qda_decoder_sva.sv
// port assertions for the quad dac address and control decoder
`include "qda_params.svh"
module qda_decoder_sva #(
	parameter int DATA_W = 12
)(
	// clock and reset
	input wire logic                         i_ref_clk,
	input wire logic                         i_srst,
	// link and strap pins
	input wire logic                         i_scl,
	input wire logic [1:0]                   i_ext_addr_pins,
	input wire logic                         o_sda,
	input wire logic                         o_sda_oe,
	// bank and status
	input wire logic [`QDA_NUM_CH*DATA_W-1:0] o_hold_code,
	input wire logic [`QDA_NUM_CH*DATA_W-1:0] o_dac_code,
	input wire logic [`QDA_NUM_CH*2-1:0]      o_dac_pd,
	input wire logic [7:0]                   o_ctrl,
	input wire logic                         o_update,
	input wire logic                         o_claimed
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);

	// reset must leave the bus released and status clear
	a_reset_quiet: assert property (disable iff (1'b0)
		i_srst |=> !o_sda_oe && !o_update && !o_claimed && o_ctrl == 8'h00)
		else $error("status not clear after reset");
	// open drain: only ever pulls low
	a_sda_low_only: assert property (o_sda == 1'b0)
		else $error("sda driven high");
	// ack may only start or end while scl is low
	a_ack_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("ack changed with scl high");
	a_ack_holds: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
		else $error("ack too short");
	a_update_claimed: assert property (o_update |-> o_claimed && !i_scl)
		else $error("update outside claimed transfer");
	a_update_gap: assert property (o_update |=> !o_update [*8])
		else $error("update repeated");
	a_bank_cause: assert property (($changed(o_dac_code) || $changed(o_hold_code)
		|| $changed(o_dac_pd)) |-> $past(o_update))
		else $error("bank changed without update");
	// a mismatched extended address still pulses update but must not touch the bank
	a_ext_match: assert property (o_update && o_ctrl[5:4] != `QDA_LOAD_BCAST
		&& o_ctrl[7:6] != i_ext_addr_pins
		|=> $stable(o_dac_code) && $stable(o_hold_code) && $stable(o_dac_pd))
		else $error("bank changed with extended address mismatch");
	a_mode0_keep: assert property (o_update && o_ctrl[5:4] == `QDA_LOAD_TEMP
		|=> $stable(o_dac_code) && $stable(o_dac_pd))
		else $error("dac changed in holding-only mode");
	a_ctrl_claimed: assert property ($changed(o_ctrl) |-> o_claimed)
		else $error("control byte taken while unclaimed");
endmodule

// file: test/qda_i2c_master.sv
// i2c bus master model: drives scl, releases sda to the pull-up
module qda_i2c_master (
	// bus lines
	output logic      o_scl,
	output logic      o_sda,
	input  wire logic i_sda_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tick;

	// 160 ns timebase, phase unrelated to the core clock
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
		tick = 1'b0;
		#13;
		forever #80 tick = ~tick;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge tick);
	endtask

	// the link pointer only resets on scl edges; sda stays high so no start forms
	task automatic flush(input int n);
		repeat (n) begin
			#7 o_scl = 1'b0;
			#7 o_scl = 1'b1;
		end
	endtask

	// start: sda falls while scl high; scl idles high between frames
	task automatic start();
		o_sda = 1'b0;
		wt(4);
		o_scl = 1'b0;
	endtask

	// write-only master, msb first; half periods of 640 ns
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			wt(1);
			o_sda = b[i];
			wt(3);
			o_scl = 1'b1;
			wt(4);
			o_scl = 1'b0;
		end
		wt(1);
		o_sda = 1'b1;
		wt(3);
		o_scl = 1'b1;
		wt(2);
		ack = ~i_sda_line;
		wt(2);
		o_scl = 1'b0;
	endtask

	// stop: sda rises while scl high
	task automatic stop();
		wt(1);
		o_sda = 1'b0;
		wt(3);
		o_scl = 1'b1;
		wt(4);
		o_sda = 1'b1;
		wt(4);
	endtask
endmodule

// file: test/qda_decoder_test.sv
// self-checking bench for the quad dac address and control decoder
module qda_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_ref_clk = 1'b0;
	logic        i_srst = 1'b1;
	logic [1:0]  i_dev_sel_pins = 2'h2;
	logic [1:0]  i_ext_addr_pins = 2'h1;
	logic        m_scl, m_sda, sda_line, o_sda, o_sda_oe, o_update, o_claimed;
	logic [47:0] o_hold_code, o_dac_code;
	logic [7:0]  o_hold_pd, o_dac_pd, o_ctrl;
	logic [11:0] eh[4] = '{default: 12'h000};
	logic [11:0] ed[4] = '{default: 12'h000};
	logic [1:0]  ehp[4] = '{default: 2'h0};
	logic [1:0]  edp[4] = '{default: 2'h0};
	int          error_cnt = 0;
	int          comparisons = 0;
	int          upd_cnt = 0;

	always #20 i_ref_clk = ~i_ref_clk;
	// count update pulses away from the edge that launches them
	always @(negedge i_ref_clk) if (o_update === 1'b1) upd_cnt++;
	// open-drain sda with pull-up
	assign sda_line = m_sda & (o_sda_oe ? o_sda : 1'b1);

	qda_i2c_master qda_i2c_master_i (.o_scl(m_scl), .o_sda(m_sda), .i_sda_line(sda_line));
	qda_decoder #(.DATA_W(12)) qda_decoder_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
		.i_scl_clk(m_scl), .i_scl(m_scl), .i_sda(sda_line), .o_sda(o_sda),
		.o_sda_oe(o_sda_oe), .i_dev_sel_pins(i_dev_sel_pins),
		.i_ext_addr_pins(i_ext_addr_pins), .o_hold_code(o_hold_code),
		.o_hold_pd(o_hold_pd), .o_dac_code(o_dac_code), .o_dac_pd(o_dac_pd),
		.o_ctrl(o_ctrl), .o_update(o_update), .o_claimed(o_claimed));

	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// expected bank effect of one upper/lower byte pair
	task automatic expect_pair(input logic [7:0] c, input logic [7:0] m, input logic [7:0] l);
		logic [1:0] md;
		logic       sel;
		logic       dac;
		md = c[5:4];
		if (md != 2'h3 && c[7:6] != i_ext_addr_pins) return;
		for (int i = 0; i < 4; i++) begin
			sel = (md == 2'h3) ? c[2] : (i == c[2:1]);
			dac = sel && md != 2'h0;
			if (sel && c[0]) begin
				// a power-down write keeps the stored code
				ehp[i] = m[7:6];
				if (dac) edp[i] = m[7:6];
			end else if (sel) begin
				eh[i] = {m, l[7:4]};
				ehp[i] = 2'h0;
				if (dac) begin
					ed[i] = {m, l[7:4]};
					edp[i] = 2'h0;
				end
			end else if (md[1]) begin
				// mode 10 others, or mode 11 with upper select clear
				ed[i] = eh[i];
				edp[i] = ehp[i];
			end
		end
	endtask

	task automatic check_bank();
		logic [47:0] h, d;
		logic [7:0]  hp, dp;
		for (int i = 0; i < 4; i++) begin
			h[i*12 +: 12] = eh[i];
			d[i*12 +: 12] = ed[i];
			hp[i*2 +: 2] = ehp[i];
			dp[i*2 +: 2] = edp[i];
		end
		check(o_hold_code, h);
		check(o_dac_code, d);
		check({40'h0, o_hold_pd}, {40'h0, hp});
		check({40'h0, o_dac_pd}, {40'h0, dp});
	endtask

	// full write frame; later bytes are sent even when unclaimed
	task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d,
		input logic k);
		logic ack;
		logic dummy;
		int   u0;
		u0 = upd_cnt;
		qda_i2c_master_i.start();
		qda_i2c_master_i.send(a, ack);
		check({47'h0, ack}, {47'h0, k});
		qda_i2c_master_i.send(c, dummy);
		check({47'h0, o_claimed}, {47'h0, k});
		qda_i2c_master_i.send(d[15:8], dummy);
		qda_i2c_master_i.send(d[7:0], dummy);
		if (k) expect_pair(c, d[15:8], d[7:0]);
		qda_i2c_master_i.stop();
		repeat (4) @(posedge i_ref_clk);
		check_bank();
		check(48'(upd_cnt - u0), {47'h0, k});
	endtask

	task automatic t_modes();
		xfer(8'h9c, 8'h52, 16'habc5, 1'b1);
		for (int ch = 0; ch < 4; ch++) begin
			xfer(8'h9c, 8'h40 | 8'(ch << 1) | 8'((ch & 1) << 3), 16'(ch * 16'h1110 + 16'h0f00), 1'b1);
		end
		check({40'h0, o_ctrl}, {40'h0, 8'h4e});
		xfer(8'h9c, 8'h60, 16'h123f, 1'b1);
		xfer(8'h9c, 8'h47, 16'hc000, 1'b1);
		xfer(8'h9c, 8'h55, 16'h4000, 1'b1);
		$display("t_modes done");
	endtask

	task automatic t_bcast();
		xfer(8'h90, 8'h34, 16'h5a5f, 1'b1);
		xfer(8'h9c, 8'h42, 16'h7770, 1'b1);
		xfer(8'h9c, 8'h53, 16'h4000, 1'b1);
		xfer(8'h90, 8'h30, 16'h0000, 1'b1);
		xfer(8'h90, 8'h35, 16'h8000, 1'b1);
		$display("t_bcast done");
	endtask

	task automatic t_refuse();
		xfer(8'h9a, 8'h52, 16'h1110, 1'b0);
		xfer(8'hdc, 8'h52, 16'h2220, 1'b0);
		xfer(8'h9d, 8'h52, 16'h3330, 1'b0);
		xfer(8'h9c, 8'h92, 16'h4440, 1'b1);
		$display("t_refuse done");
	endtask

	task automatic t_latch();
		i_dev_sel_pins <= 2'h1;
		repeat (8) @(posedge i_ref_clk);
		xfer(8'h9c, 8'h50, 16'h6660, 1'b1);
		xfer(8'h9a, 8'h50, 16'h9990, 1'b0);
		$display("t_latch done");
	endtask

	initial begin
		// link state only clears on scl edges, so clock it through and past reset
		qda_i2c_master_i.flush(5);
		@(posedge i_ref_clk);
		i_srst <= 1'b0;
		qda_i2c_master_i.flush(3);
		repeat (12) @(posedge i_ref_clk);
		check({47'h0, o_sda_oe}, 48'h0);
		check_bank();
		$display("t_reset done");
		t_modes();
		t_bcast();
		t_refuse();
		t_latch();
		complete_run();
	end

	// watchdog well beyond the expected run of about 1 ms
	initial begin
		#3_000_000;
		error_cnt++;
		complete_run();
	end
endmodule

bind qda_decoder qda_decoder_sva #(.DATA_W(DATA_W)) qda_decoder_sva_i (
	.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_scl(i_scl),
	.i_ext_addr_pins(i_ext_addr_pins), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
	.o_hold_code(o_hold_code), .o_dac_code(o_dac_code), .o_dac_pd(o_dac_pd),
	.o_ctrl(o_ctrl), .o_update(o_update), .o_claimed(o_claimed));
